// ==== pkg/scp_pkg.sv ====
// Constants and state types for the two-wire control port slave
package scp_pkg;

    // Register space
    localparam int         NREG      = 35;
    localparam logic [7:0] REG_TOP   = 8'h22;
    localparam logic [7:0] PTR_RST   = 8'h00;
    localparam logic [7:0] BYTE_RST  = 8'h00;

    // Bit framing: eight data bits, then the acknowledge pulse
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [3:0] BIT_RST   = 4'h0;

    // Slave address layout: upper bits fixed, two low bits strapped
    localparam int         ADDR_HI_W = 5;
    localparam logic [ADDR_HI_W-1:0] ADDR_HI_DEF = 5'h10;
    localparam int         RW_BIT    = 0;

    typedef enum logic [2:0] {
        LK_IDLE,
        LK_ADDR,
        LK_REGA,
        LK_WDATA,
        LK_RDATA,
        LK_IGNORE
    } link_st_e;

    // State sampled on the rising serial clock
    typedef struct packed {
        link_st_e                  st;
        logic [3:0]                bitcnt;
        logic [7:0]                sh;
        logic [7:0]                txsh;
        logic [7:0]                ptr;
        logic                      ack_want;
        logic                      rd_first;
        logic                      st_seen;
        logic                      sp_seen;
        logic [1:0]                sel_sync;
        logic [1:0]                s0_sync;
        logic [1:0]                s1_sync;
        logic                      wr_tgl;
        logic [7:0]                wr_addr;
        logic [7:0]                wr_data;
        logic [NREG-1:0][7:0]      regs;
    } link_s;

    // State updated on the falling serial clock
    typedef struct packed {
        logic                      oe;
        logic                      out;
    } drv_s;

    // System clock side of the crossing
    typedef struct packed {
        logic [2:0]                st_sync;
        logic [2:0]                sp_sync;
        logic [2:0]                wr_sync;
        logic                      active;
        logic                      strobe;
        logic [7:0]                addr;
        logic [7:0]                data;
    } sys_s;

    localparam link_s LINK_RST = '0;
    localparam drv_s  DRV_RST  = '0;
    localparam sys_s  SYS_RST  = '0;

endpackage

// ==== pkg/scp_cdc_if.sv ====
// Crossing signals from the serial clock logic to the system clock logic
`timescale 1ns/1ps
interface scp_cdc_if;
    logic       st_tgl;
    logic       sp_tgl;
    logic       wr_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    modport link (
        output st_tgl,
        output sp_tgl,
        output wr_tgl,
        output wr_addr,
        output wr_data
    );

    modport sys (
        input  st_tgl,
        input  sp_tgl,
        input  wr_tgl,
        input  wr_addr,
        input  wr_data
    );
endinterface

// ==== hdl/scp_sys_side.sv ====
// System clock receiver for write events and frame status
`timescale 1ns/1ps
module scp_sys_side
    import scp_pkg::*;
(
    // System clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Crossing from the link logic
    scp_cdc_if.sys          lk,
    // User side
    output      logic       wr_strobe,
    output      logic [7:0] wr_addr,
    output      logic [7:0] wr_data,
    output      logic       frame_active
);
    import scp_pkg::*;

    sys_s s_r;
    sys_s s_nxt;
    logic st_ev;
    logic sp_ev;
    logic wr_ev;

    // Toggles pass two flops, edge taken between second and third
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.st_sync = {s_r.st_sync[1:0], lk.st_tgl};
        s_nxt.sp_sync = {s_r.sp_sync[1:0], lk.sp_tgl};
        s_nxt.wr_sync = {s_r.wr_sync[1:0], lk.wr_tgl};
        st_ev         = s_r.st_sync[2] ^ s_r.st_sync[1];
        sp_ev         = s_r.sp_sync[2] ^ s_r.sp_sync[1];
        wr_ev         = s_r.wr_sync[2] ^ s_r.wr_sync[1];
        // Start wins over stop seen in the same cycle
        if (st_ev)
            s_nxt.active = 1'b1;
        else if (sp_ev)
            s_nxt.active = 1'b0;
        // Address and data held for a whole byte, safe to take now
        s_nxt.strobe = wr_ev;
        if (wr_ev)
        begin
            s_nxt.addr = lk.wr_addr;
            s_nxt.data = lk.wr_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_r <= SYS_RST;
        else
            s_r <= s_nxt;
    end

    assign wr_strobe    = s_r.strobe;
    assign wr_addr      = s_r.addr;
    assign wr_data      = s_r.data;
    assign frame_active = s_r.active;

endmodule

// ==== hdl/scp_slave.sv ====
// Two-wire serial control port slave with its register store
// Function
// - Data line stays stable while clock high, changes only when low.
// - Data edge while clock high is start or stop, never data.
// - Falling data with clock high from idle starts a transfer.
// - First byte after start: seven-bit address plus direction bit.
// - Direction low means master writes, high means master reads.
// - Matching address is acknowledged by pulling data low on pulse 9.
// - Address mismatch: no acknowledge, data line left released.
// - Every byte moves most significant bit first.
// - Withheld write acknowledge leaves data high for master's stop.
// - Master nack in read ends data; device releases the line.
// - Byte after write address is register address, loads the pointer.
// - Data bytes go to pointer, pointer advances one per byte.
// - Pointer saturates at 22h instead of wrapping.
// - Register address above 22h is not acknowledged.
// - Read starts at pointer kept from an earlier write transfer.
// - Pointer advances by one after each byte sent in a read.
// - Stop, rising data with clock high, returns the slave to idle.
// - Repeated start restarts address reception without a stop.
// - Port answers only while port select input is low.
// - Slave only; strap pins give up to four distinct addresses.
`timescale 1ns/1ps
module scp_slave
    import scp_pkg::*;
#(
    parameter logic [ADDR_HI_W-1:0] ADDR_HI = ADDR_HI_DEF
)
(
    // System clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Serial link, clock from the master
    input  wire logic       scl,
    input  wire logic       sda_in,
    output      logic       sda_out,
    output      logic       sda_oe,
    // Straps and port choice
    input  wire logic       port_select,
    input  wire logic       addr_strap_bit0,
    input  wire logic       addr_strap_bit1,
    // Register write events, system clock
    output      logic       wr_strobe,
    output      logic [7:0] wr_addr,
    output      logic [7:0] wr_data,
    output      logic       frame_active
);
    import scp_pkg::*;

    link_s      l_r;
    link_s      l_nxt;
    drv_s       d_r;
    drv_s       d_nxt;
    logic       st_tgl_r;
    logic       sp_tgl_r;
    logic [7:0] rx_byte;
    logic [7:0] ptr_inc;
    logic       addr_match;
    logic       start_pend;
    logic       stop_pend;
    logic       sel_off;

    scp_cdc_if lk ();

    // Start detector on the falling data line.
    // Link flops clear asynchronously: the serial clock may stand still
    // while rst is high, so a clocked clear would never land.
    // data edge with clock high
    always_ff @(negedge sda_in or posedge rst)
    begin
        if (rst)
            st_tgl_r <= 1'b0;
        else if (scl)
            st_tgl_r <= ~st_tgl_r;
    end

    // Stop detector on the rising data line
    // stop condition seen
    always_ff @(posedge sda_in or posedge rst)
    begin
        if (rst)
            sp_tgl_r <= 1'b0;
        else if (scl)
            sp_tgl_r <= ~sp_tgl_r;
    end

    // Pending events; toggles settle a half period before the next edge
    always_comb
    begin
        start_pend = st_tgl_r ^ l_r.st_seen;
        stop_pend  = sp_tgl_r ^ l_r.sp_seen;
        sel_off    = l_r.sel_sync[1];
        rx_byte    = {l_r.sh[6:0], sda_in};
    end

    // Saturating pointer step
    // hold at the top register
    always_comb
    begin
        if (l_r.ptr >= REG_TOP)
            ptr_inc = REG_TOP;
        else
            ptr_inc = l_r.ptr + 8'h01;
    end

    // Address compare against fixed bits plus straps
    // fixed upper bits
    // silent while port select is high
    always_comb
    begin
        addr_match = (rx_byte[7:1] == {ADDR_HI,
                                       l_r.s1_sync[1],
                                       l_r.s0_sync[1]})
                     && !sel_off;
    end

    // Rising clock: sample data, count bits, act on whole bytes
    always_comb
    begin
        l_nxt          = l_r;
        l_nxt.sel_sync = {l_r.sel_sync[0], port_select};
        l_nxt.s0_sync  = {l_r.s0_sync[0], addr_strap_bit0};
        l_nxt.s1_sync  = {l_r.s1_sync[0], addr_strap_bit1};
        if (start_pend)
        begin
            l_nxt.st_seen  = st_tgl_r;
            l_nxt.sp_seen  = sp_tgl_r;
            l_nxt.st       = LK_ADDR;
            l_nxt.bitcnt   = BIT_FIRST;
            l_nxt.sh       = rx_byte;
            l_nxt.ack_want = 1'b0;
            l_nxt.rd_first = 1'b0;
        end
        else if (stop_pend)
        begin
            l_nxt.sp_seen  = sp_tgl_r;
            l_nxt.st       = LK_IDLE;
            l_nxt.bitcnt   = BIT_RST;
            l_nxt.ack_want = 1'b0;
        end
        else if (l_r.st == LK_IDLE)
        begin
            l_nxt.bitcnt   = BIT_RST;
        end
        else if (l_r.bitcnt < BIT_ACK)
        begin
            // shift in most significant bit first
            l_nxt.sh     = rx_byte;
            l_nxt.bitcnt = l_r.bitcnt + BIT_FIRST;
            if (l_r.st == LK_RDATA)
                l_nxt.txsh = {l_r.txsh[6:0], 1'b0};
            if (l_r.bitcnt == BIT_LAST)
            begin
                unique case (l_r.st)
                    LK_ADDR:
                    begin
                        l_nxt.ack_want = addr_match;
                        l_nxt.rd_first = 1'b1;
                        l_nxt.txsh     = l_r.regs[l_r.ptr];
                        if (!addr_match)
                            l_nxt.st = LK_IGNORE;
                        else if (rx_byte[RW_BIT])
                            l_nxt.st = LK_RDATA;
                        else
                            l_nxt.st = LK_REGA;
                    end
                    LK_REGA:
                    begin
                        if (rx_byte <= REG_TOP)
                        begin
                            l_nxt.ack_want = 1'b1;
                            l_nxt.ptr      = rx_byte;
                            l_nxt.st       = LK_WDATA;
                        end
                        else
                        begin
                            l_nxt.ack_want = 1'b0;
                            l_nxt.st       = LK_IGNORE;
                        end
                    end
                    LK_WDATA:
                    begin
                        l_nxt.regs[l_r.ptr] = rx_byte;
                        l_nxt.wr_addr       = l_r.ptr;
                        l_nxt.wr_data       = rx_byte;
                        l_nxt.wr_tgl        = ~l_r.wr_tgl;
                        l_nxt.ptr           = ptr_inc;
                        l_nxt.ack_want      = 1'b1;
                    end
                    LK_RDATA:
                    begin
                        // Master answers this pulse, we stay off
                        l_nxt.ack_want = 1'b0;
                    end
                    LK_IGNORE:
                    begin
                        l_nxt.ack_want = 1'b0;
                    end
                    LK_IDLE:
                    begin
                        l_nxt.ack_want = 1'b0;
                    end
                endcase
            end
        end
        else
        begin
            // Ninth pulse: acknowledge slot ends
            l_nxt.bitcnt   = BIT_RST;
            l_nxt.ack_want = 1'b0;
            l_nxt.rd_first = 1'b0;
            if (l_r.st == LK_RDATA && !l_r.rd_first)
            begin
                l_nxt.ptr = ptr_inc;
                if (sda_in)
                    l_nxt.st = LK_IGNORE;
                else
                    l_nxt.txsh = l_r.regs[ptr_inc];
            end
        end
    end

    always_ff @(posedge scl or posedge rst)
    begin
        if (rst)
            l_r <= LINK_RST;
        else
            l_r <= l_nxt;
    end

    // Falling clock: only place the data line may change
    // drive changes with the clock low
    always_comb
    begin
        d_nxt     = d_r;
        d_nxt.out = 1'b0;
        d_nxt.oe  = 1'b0;
        if (!start_pend && !sel_off)
        begin
            if (l_r.bitcnt == BIT_ACK)
                d_nxt.oe = l_r.ack_want;
            else if (l_r.st == LK_RDATA)
                d_nxt.oe = ~l_r.txsh[7];
        end
    end

    always_ff @(negedge scl or posedge rst)
    begin
        if (rst)
            d_r <= DRV_RST;
        else
            d_r <= d_nxt;
    end

    // Open drain: only ever pull low
    assign sda_out = d_r.out;
    assign sda_oe  = d_r.oe;

    // Crossing toward the system clock
    assign lk.st_tgl  = st_tgl_r;
    assign lk.sp_tgl  = sp_tgl_r;
    assign lk.wr_tgl  = l_r.wr_tgl;
    assign lk.wr_addr = l_r.wr_addr;
    assign lk.wr_data = l_r.wr_data;

    // System side: write events and frame status
    scp_sys_side u_sys (
        .clock        (clock),
        .rst          (rst),
        .lk           (lk),
        .wr_strobe    (wr_strobe),
        .wr_addr      (wr_addr),
        .wr_data      (wr_data),
        .frame_active (frame_active)
    );

endmodule

// ==== tb/scp_monitor.sv ====
// Concurrent checks on the control port slave pins
`timescale 1ns/1ps
module scp_monitor
(
    // Clocks and reset
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       scl,
    // Link pins
    input wire logic       sda_in,
    input wire logic       sda_oe,
    input wire logic       port_select,
    // User side
    input wire logic       wr_strobe,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic       frame_active
);
    logic st_t;
    logic sp_t;
    logic oe_rise;

    // Start seen on the wire, toggles per event
    always_ff @(negedge sda_in or posedge rst)
        if (rst)
            st_t <= 1'b0;
        else if (scl)
            st_t <= ~st_t;

    // Stop seen on the wire
    always_ff @(posedge sda_in or posedge rst)
        if (rst)
            sp_t <= 1'b0;
        else if (scl)
            sp_t <= ~sp_t;

    // Drive level at each rise, for the high-phase check
    always_ff @(posedge scl or posedge rst)
        if (rst)
            oe_rise <= 1'b0;
        else
            oe_rise <= sda_oe;

    AST_OE_STEADY: assert property (@(negedge scl) disable iff (rst)
        sda_oe == oe_rise) else $error("drive moved while clock high");
    AST_SEL_QUIET: assert property (@(posedge scl) disable iff (rst)
        port_select [*4] |-> !sda_oe) else $error("drove while deselected");
    AST_STB_SPACE: assert property (@(posedge clock) disable iff (rst)
        wr_strobe |=> !wr_strobe [*5]) else $error("strobe too long or close");
    AST_DATA_HELD: assert property (@(posedge clock) disable iff (rst)
        !wr_strobe |-> $stable({wr_addr, wr_data}))
        else $error("write data moved without strobe");
    AST_STB_FRAME: assert property (@(posedge clock) disable iff (rst)
        wr_strobe |-> frame_active) else $error("strobe outside a frame");
    AST_FRAME_SET: assert property (@(posedge clock) disable iff (rst)
        $changed(st_t) |-> ##[2:5] frame_active) else $error("start missed");
    AST_FRAME_CLR: assert property (@(posedge clock) disable iff (rst)
        $changed(sp_t) |-> ##[2:5] !frame_active) else $error("stop missed");
    AST_SET_CAUSE: assert property (@(posedge clock) disable iff (rst)
        $rose(frame_active) |-> st_t != $past(st_t, 6))
        else $error("frame began without start");
    AST_CLR_CAUSE: assert property (@(posedge clock) disable iff (rst)
        $fell(frame_active) |-> sp_t != $past(sp_t, 6))
        else $error("frame ended without stop");
endmodule

bind scp_slave scp_monitor mon_u (.clock(clock), .rst(rst), .scl(scl),
    .sda_in(sda_in), .sda_oe(sda_oe), .port_select(port_select),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .frame_active(frame_active));

// ==== tb/scp_master.sv ====
// Behavioural two-wire bus master, clock stands high between frames
`timescale 1ns/1ps
module scp_master
(
    // Wire side
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // Idle: clock high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start();
        sda_low = 1'b0;
        #7 scl = 1'b1;
        #15 sda_low = 1'b1;
        #15 scl = 1'b0;
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        #7 scl = 1'b1;
        #8 r = sda;
        #7 scl = 1'b0;
        #8;
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic last,
                           output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, r);
        ack = ~r;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #7 scl = 1'b1;
        #15 sda_low = 1'b0;
        #15;
    endtask
endmodule

// ==== tb/serial_control_port_slave_bench.sv ====
// Self-checking bench for the two-wire control port slave
`timescale 1ns/1ps
module serial_control_port_slave_bench;
    import scp_pkg::*;
    logic        clock;
    logic        rst;
    logic        scl;
    logic        sda_low;
    logic        sda;
    logic        sda_out;
    logic        sda_oe;
    logic        port_select;
    logic [1:0]  strap;
    logic        wr_strobe;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        frame_active;
    logic [15:0] sq[$];
    logic [7:0]  rx;
    logic        ak;
    int          num_errors = 0;
    int          checks_done = 0;

    // Open-drain wire with pull-up
    assign sda = ~sda_low & (sda_oe ? sda_out : 1'b1);

    scp_slave dut_u (.clock(clock), .rst(rst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .port_select(port_select),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
        .frame_active(frame_active));
    scp_master m_u (.scl(scl), .sda_low(sda_low), .sda(sda));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Log every register write event
    always @(posedge clock)
        if (wr_strobe === 1'b1)
            sq.push_back({wr_addr, wr_data});

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic [7:0] sa(input logic [1:0] s, input logic rw);
        return {ADDR_HI_DEF, s, rw};
    endfunction

    // Byte from master, acknowledge compared
    task automatic put(input logic [7:0] b, input logic exp_ack);
        m_u.byte_io(b, 1'b1, rx, ak);
        check({7'h00, ak}, {7'h00, exp_ack});
    endtask

    task automatic get(input logic [7:0] exp, input logic last);
        m_u.byte_io(8'hFF, last, rx, ak);
        check(rx, exp);
    endtask

    // Stop, then let the frame flag settle
    task automatic fin();
        m_u.stop();
        repeat (8) @(posedge clock);
        #2;
    endtask

    task automatic t_burst();
        sq.delete();
        m_u.start();
        put(sa(2'b00, 1'b0), 1'b1);
        put(8'h20, 1'b1);
        for (int i = 0; i < 4; i++)
            put(8'hA0 + 8'(i), 1'b1);
        fin();
        check(8'(sq.size()), 8'h04);
        foreach (sq[i])
        begin
            check(sq[i][15:8], (i < 2) ? 8'h20 + 8'(i) : REG_TOP);
            check(sq[i][7:0], 8'hA0 + 8'(i));
        end
    endtask

    task automatic t_read();
        m_u.start();
        put(sa(2'b00, 1'b0), 1'b1);
        put(8'h21, 1'b1);
        fin();
        m_u.start();
        put(sa(2'b00, 1'b1), 1'b1);
        get(8'hA1, 1'b0);
        get(8'hA3, 1'b0);
        get(8'hA3, 1'b1);
        check({7'h00, sda_oe}, 8'h00);
        fin();
    endtask

    task automatic t_rep();
        m_u.start();
        put(sa(2'b00, 1'b0), 1'b1);
        put(8'h20, 1'b1);
        m_u.start();
        put(sa(2'b00, 1'b1), 1'b1);
        get(8'hA0, 1'b0);
        get(8'hA1, 1'b1);
        fin();
    endtask

    task automatic t_bad();
        sq.delete();
        m_u.start();
        put(sa(2'b00, 1'b0), 1'b1);
        put(8'h23, 1'b0);
        put(8'h5A, 1'b0);
        m_u.start();
        put(sa(2'b00, 1'b0), 1'b1);
        put(REG_TOP, 1'b1);
        put(8'h77, 1'b1);
        fin();
        check(8'(sq.size()), 8'h01);
        check(sq[0][15:8], REG_TOP);
    endtask

    // Every strap setting against every address
    task automatic t_addr();
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 4; k++)
            begin
                strap = 2'(s);
                m_u.start();
                put(sa(2'(k), 1'b0), 1'(s == k));
                fin();
            end
        strap = 2'b00;
    endtask

    task automatic t_off();
        port_select = 1'b1;
        m_u.start();
        put(sa(2'b00, 1'b0), 1'b0);
        fin();
        port_select = 1'b0;
    endtask

    initial
    begin
        rst = 1'b1;
        port_select = 1'b0;
        strap = 2'b00;
        repeat (6) @(posedge clock);
        #2 rst = 1'b0;
        t_burst();
        t_read();
        t_rep();
        t_bad();
        t_addr();
        t_off();
        t_rep();
        end_of_test();
    end

    // Guard against a hung transfer
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule
